// [tpb_bridge.sv]
// timing packet bridge: classifier, stamp engine, scheduler and buffers
`timescale 1ns/1ps

// ----------------------------------------
// flip-flop fifo
// ----------------------------------------
module tpb_fifo #(
  parameter int W = 9,
  parameter int N = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (N > 1) ? $clog2(N) : 1;
  logic [W-1:0] mem_q [N];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic wr, rd;
  assign in_ready_o = cnt_q != (AW+1)'(N);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rp_q];
  assign wr = in_valid_i && in_ready_o;
  assign rd = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (wr) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (wr) wp_q <= (wp_q == AW'(N - 1)) ? '0 : wp_q + 1'b1;
      if (rd) rp_q <= (rp_q == AW'(N - 1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

// ----------------------------------------
// one direction: classify, stamp, frame
// ----------------------------------------
module tpb_path
  import tpb_pkg::*;
#(
  parameter bit IS_RX = 1'b0,
  parameter int BC_CYC = BC_UNIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [7:0] in_data_i,
  input wire logic in_last_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  output logic out_last_o,
  input wire logic out_ready_i,
  input wire logic [HDR_W-1:0] mask_i,
  input wire logic [HDR_W-1:0] match_i,
  input wire tpb_fmt_t fmt_i,
  input wire logic [63:0] now_i,
  input wire logic [63:0] arr_ts_i,
  input wire logic [5:0] act_ofs_i,
  input wire logic [5:0] ts_ofs_i,
  input wire logic [5:0] csum_ofs_i,
  input wire logic csum_en_i,
  input wire logic [2:0] bc_win_i,
  input wire logic [7:0] bc_lim_i,
  output logic fu_push_o,
  output logic [63:0] fu_ts_o
);
  tpb_st_t st_q;
  logic [7:0] hdr_q [HDR_N];
  logic [HDR_W-1:0] hdr_v;
  logic [6:0] cnt_q;
  logic [5:0] oi_q;
  logic more_q, tim_q;
  logic [2:0] act_q;
  logic [63:0] ts_q, tgt;
  logic [31:0] crc_q;
  logic [BC_WIN_W-1:0] win_q, win_end;
  logic [7:0] bc_q;
  logic [3:0] tlen;
  logic [15:0] csum_old, csum_new;
  logic hit, bcast, drop, due, fire, sched, stamp_end;

  for (genvar i = 0; i < HDR_N; i++) begin : g_hv
    assign hdr_v[i*8 +: 8] = hdr_q[i];
  end

  // mask bit 1 drops that bit from the compare
  assign hit = ((hdr_v ^ match_i) & ~mask_i) == '0;
  assign bcast = (&hdr_v[47:0]) || ({hdr_q[ETYPE_OFS], hdr_q[ETYPE_OFS+1]} == ARP_TYPE);
  assign drop = IS_RX && bcast && (bc_q >= bc_lim_i);
  assign tlen = (fmt_i == TS_RTP) ? 4'h4 : 4'h8;
  // only the tx side reads an action field
  assign sched = !IS_RX && hit && hdr_q[act_ofs_i][ACT_SCHED];
  assign due = now_i >= tgt;
  assign fire = out_valid_o && out_ready_i;
  assign stamp_end = IS_RX && tim_q;
  assign csum_old = {hdr_q[csum_ofs_i], hdr_q[6'(csum_ofs_i + 6'h01)]};

  always_comb begin
    tgt = '0;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < tlen) tgt = {tgt[55:0], hdr_q[6'(ts_ofs_i + 6'(k))]};
    end
  end

  // incremental one's complement update over the replaced words
  always_comb begin
    logic [31:0] s;
    s = {16'h0000, ~csum_old};
    for (int w = 0; w < 4; w++) begin
      if (4'(2 * w) < tlen) begin
        s = s + {16'h0000, ~{hdr_q[6'(ts_ofs_i + 6'(2 * w))],
                             hdr_q[6'(ts_ofs_i + 6'(2 * w + 1))]}};
        s = s + {16'h0000, ts_byte(now_i, tlen, 4'(2 * w)),
                 ts_byte(now_i, tlen, 4'(2 * w + 1))};
      end
    end
    s = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
    s = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
    csum_new = (s[15:0] == 16'hFFFF) ? 16'hFFFF : ~s[15:0];
  end

  // ----------------------------------------
  // packet sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      oi_q <= '0;
      more_q <= 1'b0;
      tim_q <= 1'b0;
      act_q <= '0;
      ts_q <= '0;
      crc_q <= CRC_INIT;
      for (int i = 0; i < HDR_N; i++) hdr_q[i] <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          // short frames compare against zero padding
          for (int i = 1; i < HDR_N; i++) hdr_q[i] <= '0;
          if (in_valid_i) begin
            hdr_q[0] <= in_data_i;
            cnt_q <= 7'h01;
            more_q <= !in_last_i;
            // arrival time latched with the first byte
            if (IS_RX) ts_q <= arr_ts_i;
            st_q <= in_last_i ? ST_CLS : ST_FILL;
          end
        end
        ST_FILL: begin
          if (in_valid_i) begin
            hdr_q[cnt_q[5:0]] <= in_data_i;
            cnt_q <= cnt_q + 7'h01;
            if (in_last_i) begin
              more_q <= 1'b0;
              st_q <= ST_CLS;
            end else if (cnt_q == 7'(HDR_N - 1)) begin
              st_q <= ST_CLS;
            end
          end
        end
        ST_CLS: begin
          tim_q <= hit;
          act_q <= (!IS_RX && hit) ? hdr_q[act_ofs_i][2:0] : 3'h0;
          // limiter ahead of the forwarding decision
          if (drop) st_q <= more_q ? ST_DROP : ST_IDLE;
          else if (sched) st_q <= ST_WAIT;
          else st_q <= ST_PREP;
        end
        ST_WAIT: begin
          if (due) st_q <= ST_PREP;
        end
        ST_PREP: begin
          if (!IS_RX) ts_q <= now_i;
          // exit stamp written over the header field
          if (!IS_RX && act_q[ACT_INS]) begin
            for (int k = 0; k < 8; k++) begin
              if (4'(k) < tlen) hdr_q[6'(ts_ofs_i + 6'(k))] <= ts_byte(now_i, tlen, 4'(k));
            end
            if (csum_en_i && csum_old != 16'h0000) begin
              hdr_q[csum_ofs_i] <= csum_new[15:8];
              hdr_q[6'(csum_ofs_i + 6'h01)] <= csum_new[7:0];
            end
          end
          oi_q <= '0;
          crc_q <= CRC_INIT;
          st_q <= ST_HDR;
        end
        ST_HDR: begin
          if (fire) begin
            crc_q <= crc_byte(crc_q, out_data_o);
            oi_q <= oi_q + 6'h01;
            if (7'(oi_q) == cnt_q - 7'h01) begin
              oi_q <= '0;
              st_q <= more_q ? ST_BODY : (stamp_end ? ST_TS : ST_FCS);
            end
          end
        end
        ST_BODY: begin
          if (fire) begin
            crc_q <= crc_byte(crc_q, out_data_o);
            if (in_last_i) st_q <= stamp_end ? ST_TS : ST_FCS;
          end
        end
        ST_TS: begin
          if (fire) begin
            crc_q <= crc_byte(crc_q, out_data_o);
            oi_q <= oi_q + 6'h01;
            if (4'(oi_q) == tlen - 4'h1) begin
              oi_q <= '0;
              st_q <= ST_FCS;
            end
          end
        end
        ST_FCS: begin
          if (fire) begin
            oi_q <= oi_q + 6'h01;
            if (oi_q == 6'h03) st_q <= ST_IDLE;
          end
        end
        ST_DROP: begin
          if (in_valid_i && in_last_i) st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // stream outputs
  // ----------------------------------------
  always_comb begin
    in_ready_o = 1'b0;
    out_valid_o = 1'b0;
    out_data_o = '0;
    case (st_q)
      ST_IDLE, ST_FILL, ST_DROP: in_ready_o = 1'b1;
      ST_HDR: begin
        out_valid_o = 1'b1;
        out_data_o = hdr_q[oi_q];
      end
      ST_BODY: begin
        in_ready_o = out_ready_i;
        out_valid_o = in_valid_i;
        out_data_o = in_data_i;
      end
      // arrival stamp appended after the last byte
      // stamp sits past the datagram end
      ST_TS: begin
        out_valid_o = 1'b1;
        out_data_o = ts_byte(ts_q, tlen, 4'(oi_q));
      end
      // fresh sequence on every frame out
      ST_FCS: begin
        out_valid_o = 1'b1;
        out_data_o = 8'((~crc_q) >> ({2'b00, oi_q} * 8'h08));
      end
      default: out_valid_o = 1'b0;
    endcase
  end
  assign out_last_o = (st_q == ST_FCS) && (oi_q == 6'h03);
  // exit time recorded when the packet starts out
  assign fu_push_o = !IS_RX && (st_q == ST_PREP) && act_q[ACT_REC];
  assign fu_ts_o = now_i;

  // ----------------------------------------
  // broadcast window counter
  // ----------------------------------------
  assign win_end = BC_WIN_W'((BC_CYC << bc_win_i) - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q <= '0;
      bc_q <= '0;
    end else if (win_q >= win_end) begin
      win_q <= '0;
      bc_q <= '0;
    end else begin
      win_q <= win_q + 1'b1;
      if (IS_RX && st_q == ST_CLS && bcast && !drop && bc_q != 8'hFF) bc_q <= bc_q + 8'h01;
    end
  end

  sequence s_wait_due;
    st_q == ST_WAIT && due;
  endsequence
  sequence s_play;
    st_q == ST_PREP ##1 st_q == ST_HDR;
  endsequence

  a_class_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_CLS |=> tim_q == $past(hit)) else $error("timing flag mismatch");
  a_bcast_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_CLS && drop |=> st_q == ST_DROP || st_q == ST_IDLE)
    else $error("over-limit broadcast forwarded");
  a_sched_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_WAIT && !due |=> st_q == ST_WAIT) else $error("left hold early");
  a_sched_play: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wait_due |=> s_play) else $error("late playout");
  a_frame_end: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && out_last_o |-> st_q == ST_FCS ##1 st_q == ST_IDLE)
    else $error("frame end outside check sequence");
  a_rx_append: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_BODY && fire && in_last_i && stamp_end |=> st_q == ST_TS)
    else $error("arrival stamp skipped");
  a_ts_insert: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_PREP && !IS_RX && act_q[ACT_INS] |=> hdr_q[ts_ofs_i] == ts_byte($past(now_i), tlen, 4'h0))
    else $error("exit stamp not written");
endmodule

// ----------------------------------------
// top: link sampling, two paths, buffers
// ----------------------------------------
// Notes on behaviour
// - network frames pass the broadcast limiter, then the classifier
// - received timing frames get arrival time appended; others unchanged
// - small buffer queues all frames toward the processor port
// - frame start on the link captures the arrival time
// - processor frames classified; timing ones scheduled or sent at once
// - requested exit times go with a unique index into a 64-deep queue
// - first 64 header bytes compared bitwise under a mask
// - one timing or non-timing decision per frame
// - separate rule set for each direction
// - mask bit 1 excludes that bit; 0 demands equality
// - action field bits: record, insert, schedule, in any mix
// - insertion writes exit stamp at its configured header offset
// - after insertion the UDP checksum and frame check are redone
// - stamps taken within a few clocks of the link edge
// - stamp format PTP or NTP at 64 bits, RTP at 32
// - RTP stamp is a 32-bit count of 10 MHz periods
// - arrival stamp placed past the datagram, fields untouched
// - received timing frames keep UDP checksum; frame check redone
// - one scheduled frame at a time waits for its time; later frames are held upstream
// - schedule bit holds the frame until its stamp time
// - scheduled frame starts within one microsecond of its time
// - received broadcast or ARP frames above the window limit are dropped
// - non-timing frames pass unchanged, lost only on overflow or to the broadcast limiter
module tpb_bridge
  import tpb_pkg::*;
#(
  parameter int BC_CYC = BC_UNIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic net_rx_clk_i,
  input wire logic net_rx_dv_i,
  input wire logic [7:0] net_rx_d_i,
  output logic cpu_tx_valid_o,
  output logic [7:0] cpu_tx_data_o,
  output logic cpu_tx_last_o,
  input wire logic cpu_tx_ready_i,
  input wire logic cpu_rx_valid_i,
  input wire logic [7:0] cpu_rx_data_i,
  input wire logic cpu_rx_last_i,
  output logic cpu_rx_ready_o,
  output logic net_tx_valid_o,
  output logic [7:0] net_tx_data_o,
  output logic net_tx_last_o,
  input wire logic net_tx_ready_i,
  input wire logic [HDR_W-1:0] tx_mask_i,
  input wire logic [HDR_W-1:0] tx_match_i,
  input wire logic [HDR_W-1:0] rx_mask_i,
  input wire logic [HDR_W-1:0] rx_match_i,
  input wire tpb_fmt_t ts_fmt_i,
  input wire logic [63:0] tb_ptp_i,
  input wire logic [63:0] tb_ntp_i,
  input wire logic [31:0] tb_rtp_i,
  input wire logic [5:0] act_ofs_i,
  input wire logic [5:0] ts_ofs_i,
  input wire logic [5:0] csum_ofs_i,
  input wire logic csum_en_i,
  input wire logic [2:0] bc_win_i,
  input wire logic [7:0] bc_lim_i,
  input wire logic fu_rd_i,
  output logic fu_valid_o,
  output logic [63:0] fu_ts_o,
  output logic [FU_IDX_W-1:0] fu_idx_o,
  output logic fu_ovf_o,
  input wire logic fu_ovf_clr_i
);
  logic [2:0] ck_s;
  logic [1:0] dv_s;
  logic [7:0] d_s0, d_s1, pend_q;
  logic dv_q, pend_v_q, edge_w, lk_push, lk_rdy, lk_v, lk_r, fu_push, fu_rdy;
  logic [8:0] lk_d;
  logic [63:0] now_fmt, arr_q, fu_ts;
  logic rx_v, rx_l, rx_r, tx_v, tx_l, tx_r, tx_l_n;
  logic [7:0] rx_d, tx_d, rx_d_n;
  logic [FU_IDX_W-1:0] idx_q;
  logic [FU_IDX_W+63:0] fu_q;

  // RTP count zero-extended from the time base
  always_comb begin
    case (ts_fmt_i)
      TS_NTP: now_fmt = tb_ntp_i;
      TS_RTP: now_fmt = {32'h00000000, tb_rtp_i};
      default: now_fmt = tb_ptp_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_s <= '0;
      dv_s <= '0;
      d_s0 <= '0;
      d_s1 <= '0;
    end else begin
      ck_s <= {ck_s[1:0], net_rx_clk_i};
      dv_s <= {dv_s[0], net_rx_dv_i};
      d_s0 <= net_rx_d_i;
      d_s1 <= d_s0;
    end
  end
  assign edge_w = ck_s[1] && !ck_s[2];
  // one byte held back so the frame end can mark it last;
  // the link clock may stop after a frame, so a dv fall alone also closes it
  assign lk_push = pend_v_q && (edge_w || !dv_s[1]);
  assign lk_d = {!dv_s[1], pend_q};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dv_q <= 1'b0;
      pend_v_q <= 1'b0;
      pend_q <= '0;
      arr_q <= '0;
    end else if (edge_w) begin
      dv_q <= dv_s[1];
      // fixed sampling delay keeps the stamp error small
      if (dv_s[1] && !dv_q) arr_q <= now_fmt;
      pend_v_q <= dv_s[1];
      if (dv_s[1]) pend_q <= d_s1;
    end else if (pend_v_q && !dv_s[1]) begin
      dv_q <= 1'b0;
      pend_v_q <= 1'b0;
    end
  end

  // link bytes lost only when this buffer overflows
  tpb_fifo #(.W(9), .N(LINK_FIFO_N)) u_lk (
    .clk_i(clk_i), .rst_i(rst_i), .in_valid_i(lk_push), .in_ready_o(lk_rdy),
    .in_data_i(lk_d), .out_valid_o(lk_v), .out_ready_i(lk_r), .out_data_o({rx_l, rx_d}));

  tpb_path #(.IS_RX(1'b1), .BC_CYC(BC_CYC)) u_rx (
    .clk_i(clk_i), .rst_i(rst_i), .in_valid_i(lk_v), .in_data_i(rx_d), .in_last_i(rx_l),
    .in_ready_o(lk_r), .out_valid_o(rx_v), .out_data_o(tx_d), .out_last_o(tx_l),
    .out_ready_i(tx_r), .mask_i(rx_mask_i), .match_i(rx_match_i), .fmt_i(ts_fmt_i),
    .now_i(now_fmt), .arr_ts_i(arr_q), .act_ofs_i(act_ofs_i), .ts_ofs_i(ts_ofs_i),
    .csum_ofs_i(csum_ofs_i), .csum_en_i(1'b0), .bc_win_i(bc_win_i), .bc_lim_i(bc_lim_i),
    .fu_push_o(), .fu_ts_o());

  // two-entry buffer toward the processor port
  tpb_fifo #(.W(9), .N(OUT_FIFO_N)) u_cpu_out (
    .clk_i(clk_i), .rst_i(rst_i), .in_valid_i(rx_v), .in_ready_o(tx_r),
    .in_data_i({tx_l, tx_d}), .out_valid_o(cpu_tx_valid_o), .out_ready_i(cpu_tx_ready_i),
    .out_data_o({cpu_tx_last_o, cpu_tx_data_o}));

  // processor frames classified on the way out
  // scheduled frames wait upstream under back-pressure
  tpb_path #(.IS_RX(1'b0), .BC_CYC(BC_CYC)) u_tx (
    .clk_i(clk_i), .rst_i(rst_i), .in_valid_i(cpu_rx_valid_i), .in_data_i(cpu_rx_data_i),
    .in_last_i(cpu_rx_last_i), .in_ready_o(cpu_rx_ready_o), .out_valid_o(tx_v),
    .out_data_o(rx_d_n), .out_last_o(tx_l_n), .out_ready_i(rx_r),
    .mask_i(tx_mask_i), .match_i(tx_match_i), .fmt_i(ts_fmt_i), .now_i(now_fmt),
    .arr_ts_i(64'h0000000000000000), .act_ofs_i(act_ofs_i), .ts_ofs_i(ts_ofs_i),
    .csum_ofs_i(csum_ofs_i), .csum_en_i(csum_en_i), .bc_win_i(bc_win_i),
    .bc_lim_i(bc_lim_i), .fu_push_o(fu_push), .fu_ts_o(fu_ts));

  tpb_fifo #(.W(9), .N(OUT_FIFO_N)) u_net_out (
    .clk_i(clk_i), .rst_i(rst_i), .in_valid_i(tx_v), .in_ready_o(rx_r),
    .in_data_i({tx_l_n, rx_d_n}), .out_valid_o(net_tx_valid_o), .out_ready_i(net_tx_ready_i),
    .out_data_o({net_tx_last_o, net_tx_data_o}));

  // exit time queued with a packet index
  tpb_fifo #(.W(FU_IDX_W + 64), .N(FU_DEPTH)) u_fu (
    .clk_i(clk_i), .rst_i(rst_i), .in_valid_i(fu_push), .in_ready_o(fu_rdy),
    .in_data_i({idx_q, fu_ts}), .out_valid_o(fu_valid_o), .out_ready_i(fu_rd_i),
    .out_data_o(fu_q));
  assign fu_idx_o = fu_q[FU_IDX_W+63:64];
  assign fu_ts_o = fu_q[63:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q <= '0;
      fu_ovf_o <= 1'b0;
    end else begin
      if (fu_push) idx_q <= idx_q + 1'b1;
      // full queue keeps old entries; set beats clear
      if (fu_push && !fu_rdy) fu_ovf_o <= 1'b1;
      else if (fu_ovf_clr_i) fu_ovf_o <= 1'b0;
    end
  end

  a_arr_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    edge_w && dv_s[1] && !dv_q |=> arr_q == $past(now_fmt))
    else $error("arrival time not captured");
  a_fu_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    fu_push && !fu_rdy |=> fu_ovf_o && fu_valid_o) else $error("overflow not flagged");
  a_fu_index: assert property (@(posedge clk_i) disable iff (rst_i)
    fu_push |=> idx_q == $past(idx_q) + 1'b1) else $error("index not advanced");
endmodule

// [tpb_bridge_tb.sv]
// self-checking bench of the timing packet bridge
`timescale 1ns/1ps
module tpb_bridge_tb;
  import tpb_pkg::*;
  typedef logic [7:0] tpb_bq_t[$];
  logic clk_i = 1'b0, rst_i = 1'b1, ci_v = 1'b0, ci_l = 1'b0, co_r = 1'b1, no_r = 1'b1;
  logic fu_rd = 1'b0, csum_en = 1'b1, ovf_clr = 1'b0;
  logic [2:0] bwin = 3'h7;
  logic [7:0] ci_d = 8'h00, lim = 8'h00;
  logic [63:0] ptp = 64'h1000, ntp = 64'h0A0B0C0D01020304, t;
  logic [31:0] rtp = 32'h5A5A1234;
  logic [HDR_W-1:0] msk = {{504{1'b1}}, 8'h00};
  tpb_fmt_t fmt = TS_PTP;
  wire nclk, ndv, co_v, co_l, ci_r, no_v, no_l, fu_v, fu_o;
  wire [7:0] nd, co_d, no_d;
  wire [63:0] fu_t;
  wire [FU_IDX_W-1:0] fu_i;
  int n_errors = 0, check_count = 0, cyc = 0;
  tpb_bq_t q, e;

  tpb_net_phy tpb_net_phy_inst (.rx_clk_o(nclk), .rx_dv_o(ndv), .rx_d_o(nd));
  tpb_bridge #(.BC_CYC(10)) tpb_bridge_inst (
    .clk_i(clk_i), .rst_i(rst_i), .net_rx_clk_i(nclk), .net_rx_dv_i(ndv), .net_rx_d_i(nd),
    .cpu_tx_valid_o(co_v), .cpu_tx_data_o(co_d), .cpu_tx_last_o(co_l), .cpu_tx_ready_i(co_r),
    .cpu_rx_valid_i(ci_v), .cpu_rx_data_i(ci_d), .cpu_rx_last_i(ci_l), .cpu_rx_ready_o(ci_r),
    .net_tx_valid_o(no_v), .net_tx_data_o(no_d), .net_tx_last_o(no_l), .net_tx_ready_i(no_r),
    .tx_mask_i(msk), .tx_match_i(512'hAA), .rx_mask_i(msk), .rx_match_i(512'h55),
    .ts_fmt_i(fmt), .tb_ptp_i(ptp), .tb_ntp_i(ntp), .tb_rtp_i(rtp), .act_ofs_i(6'h01),
    .ts_ofs_i(6'h08), .csum_ofs_i(6'h10), .csum_en_i(csum_en), .bc_win_i(bwin), .bc_lim_i(lim),
    .fu_rd_i(fu_rd), .fu_valid_o(fu_v), .fu_ts_o(fu_t), .fu_idx_o(fu_i), .fu_ovf_o(fu_o),
    .fu_ovf_clr_i(ovf_clr));

  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic tpb_bq_t mk(input logic [7:0] b0, input logic [7:0] b1);
    tpb_bq_t r;
    for (int i = 0; i < 20; i++) r.push_back(i == 0 ? b0 : i == 1 ? b1 : 8'(i));
    return r;
  endfunction
  // frame check appended low byte first
  function automatic tpb_bq_t fcs(input tpb_bq_t r);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (r[i]) begin
      c = c ^ {24'h000000, r[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    c = ~c;
    for (int k = 0; k < 4; k++) r.push_back(c[8*k +: 8]);
    return r;
  endfunction
  task automatic send_cpu(input tpb_bq_t r);
    foreach (r[i]) begin
      @(posedge clk_i);
      #1 ci_v = 1'b1;
      ci_d = r[i];
      ci_l = (i == r.size() - 1);
      @(negedge clk_i);
      while (ci_r !== 1'b1) @(negedge clk_i);
    end
    @(posedge clk_i);
    #1 ci_v = 1'b0;
    ci_l = 1'b0;
  endtask
  // receiver stalls one cycle in four; lim bounds each wait
  task automatic recv(input bit net, input tpb_bq_t x, input int lim);
    int i, w;
    i = 0;
    w = 0;
    while (i < x.size() && w < lim) begin
      @(negedge clk_i);
      if ((net ? no_v : co_v) === 1'b1 && (net ? no_r : co_r)) begin
        chk(net ? no_d : co_d, x[i]);
        chk(net ? no_l : co_l, i == x.size() - 1);
        i++;
        w = 0;
      end else w++;
      @(posedge clk_i);
      #1 co_r = (cyc % 4 != 0);
      no_r = co_r;
    end
    chk(i, x.size());
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    q = mk(8'h11, 8'h03);
    fork send_cpu(q); recv(1, fcs(q), 200); join
    $display("test tx plain done");
    q = mk(8'hAA, 8'h03);
    e = q;
    for (int k = 0; k < 8; k++) e[8+k] = ptp[8*(7-k) +: 8];
    // udp sum 1011 updated by hand for words 0809..0E0F replaced by the stamp
    e[16] = 8'h2C;
    e[17] = 8'h41;
    fork send_cpu(q); recv(1, fcs(e), 200); join
    @(negedge clk_i);
    chk(fu_v, 1);
    chk(fu_t, ptp);
    chk(fu_i, 0);
    @(posedge clk_i);
    #1 fu_rd = 1'b1;
    @(posedge clk_i);
    #1 fu_rd = 1'b0;
    @(negedge clk_i);
    chk(fu_v, 0);
    $display("test tx insert done");
    q = mk(8'hAA, 8'h04);
    for (int k = 0; k < 8; k++) q[8+k] = k == 6 ? 8'h20 : 8'h00;
    send_cpu(q);
    repeat (100) begin
      @(negedge clk_i);
      chk(no_v, 0);
    end
    @(posedge clk_i);
    #1 ptp = 64'h2000;
    recv(1, fcs(q), SCHED_TOL_CYC);
    $display("test schedule done");
    for (int f = 0; f < 3; f++) begin
      fmt = tpb_fmt_t'(f);
      t = f == 0 ? ptp : f == 1 ? ntp : {32'h00000000, rtp};
      q = mk(8'h55, 8'h00);
      e = q;
      for (int k = (f == 2 ? 3 : 7); k >= 0; k--) e.push_back(t[8*k +: 8]);
      fork tpb_net_phy_inst.send(q); recv(0, fcs(e), 3000); join
    end
    $display("test rx stamp done");
    e = mk(8'hFF, 8'hFF);
    for (int k = 2; k < 6; k++) e[k] = 8'hFF;
    q = mk(8'h11, 8'h00);
    fork
      begin
        tpb_net_phy_inst.send(e);
        tpb_net_phy_inst.send(q);
      end
      recv(0, fcs(q), 5000);
    join
    $display("test rx broadcast done");
    @(posedge clk_i);
    #1 no_r = 1'b1;
    chk(fu_o, 0);
    q = '{8'hAA, 8'h01};
    // one more record than the queue holds
    repeat (65) send_cpu(q);
    repeat (20) @(negedge clk_i);
    chk(fu_o, 1);
    chk(fu_i, 1);
    @(posedge clk_i);
    #1 ovf_clr = 1'b1;
    @(posedge clk_i);
    #1 ovf_clr = 1'b0;
    @(negedge clk_i);
    chk(fu_o, 0);
    $display("test overflow done");
    stop_test();
  end
endmodule

// [tpb_net_phy.sv]
// network-side link model that sends frames into the bridge
`timescale 1ns/1ps
module tpb_net_phy (
  output logic rx_clk_o,
  output logic rx_dv_o,
  output logic [7:0] rx_d_o
);
  initial begin
    rx_clk_o = 1'b0;
    rx_dv_o = 1'b0;
    rx_d_o = 8'h00;
  end
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      rx_d_o = q[i];
      rx_dv_o = 1'b1;
      #80 rx_clk_o = 1'b1;
      #80 rx_clk_o = 1'b0;
    end
    // clock stands low; data flips so a stale byte cannot pass for good
    rx_dv_o = 1'b0;
    rx_d_o = ~rx_d_o;
    #1600;
  endtask
endmodule

// [tpb_pkg.sv]
// shared constants, types and helpers of the timing packet bridge
package tpb_pkg;
  localparam int HDR_N = 64;
  localparam int HDR_W = HDR_N * 8;
  localparam int CLK_NS = 10;
  localparam int BC_UNIT_NS = 100000;
  localparam int BC_UNIT_CYC = BC_UNIT_NS / CLK_NS;
  localparam int BC_WIN_W = 21;
  localparam int SCHED_TOL_NS = 1000;
  localparam int SCHED_TOL_CYC = SCHED_TOL_NS / CLK_NS;
  localparam int FU_DEPTH = 64;
  localparam int FU_IDX_W = 16;
  localparam int LINK_FIFO_N = 16;
  localparam int OUT_FIFO_N = 2;
  localparam int ACT_REC = 0;
  localparam int ACT_INS = 1;
  localparam int ACT_SCHED = 2;
  localparam int ETYPE_OFS = 12;
  localparam logic [15:0] ARP_TYPE = 16'h0806;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;

  typedef enum logic [1:0] {
    TS_PTP = 2'b00,
    TS_NTP = 2'b01,
    TS_RTP = 2'b10
  } tpb_fmt_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_FILL = 4'b0001,
    ST_CLS = 4'b0010,
    ST_WAIT = 4'b0011,
    ST_PREP = 4'b0100,
    ST_HDR = 4'b0101,
    ST_BODY = 4'b0110,
    ST_TS = 4'b0111,
    ST_FCS = 4'b1000,
    ST_DROP = 4'b1001
  } tpb_st_t;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // big-endian byte k of a stamp that is 4 or 8 bytes long
  function automatic logic [7:0] ts_byte(input logic [63:0] ts, input logic [3:0] len,
                                         input logic [3:0] k);
    logic [63:0] s;
    s = ts >> (6'(len - k - 4'h1) * 6'h08);
    return s[7:0];
  endfunction
endpackage
